// File: logic/shp_host_port.sv
/*
  Pin-level SRAM-like host port: strobe decode, 16/32-bit packing,
  CSR file, TX/RX data FIFO ports, interrupt pin, wake on host write,
  and the word FIFO that buffers both data directions.
  Assumes host pins are asynchronous to sys_clk and strobes last at
  least four sys_clk periods; MAC side is on sys_clk.
*/
`default_nettype none
`include "shp_cfg.svh"
// Word FIFO for both data directions; one clock, synchronous reset
module shp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  // Memory has no reset; an empty FIFO shows stale data
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  // Count carries one extra bit so that full and empty differ
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_next  = push ? AW'((wp_reg + 1'b1) % DEPTH) : wp_reg;
    rp_next  = pop ? AW'((rp_reg + 1'b1) % DEPTH) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule

module shp_host_port #(
  parameter int DEPTH = `SHP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Host bus pins
  input  wire shp_pkg::shp_hbus_t       hbus,
  input  wire logic [`SHP_HDATA_W-1:0]  hdata_in,
  output logic [`SHP_HDATA_W-1:0]       hdata_out,
  output logic                          hdata_oe_n,
  // Interrupt pin
  output logic                          irq_out,
  output logic                          irq_oe_n,
  // Interrupt sources from the MAC
  input  wire logic [3:0]               irq_src,
  // Transmit words toward the MAC
  output shp_pkg::shp_word_t            tx_word,
  input  wire logic                     tx_ready,
  // Receive words from the MAC
  input  wire shp_pkg::shp_word_t       rx_word,
  output logic                          rx_ready,
  // Power state
  output logic                          sleep
);
  import shp_pkg::*;

  // Byte-lane swap for a big-endian host; FIFO data is never swapped
  function automatic logic [`SHP_WORD_W-1:0] swap32(
    input logic [`SHP_WORD_W-1:0] w, input logic en);
    swap32 = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  // Two-flop synchronisers on all host pins
  // Decode reads only the second stage, never the metastable first one
  shp_hbus_t                hb_s1_reg, hb_s2_reg;
  logic [`SHP_HDATA_W-1:0]  hd_s1_reg, hd_s2_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hb_s1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      hb_s2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      hd_s1_reg <= '0;
      hd_s2_reg <= '0;
    end else begin
      hb_s1_reg <= hbus;
      hb_s2_reg <= hb_s1_reg;
      hd_s1_reg <= hdata_in;
      hd_s2_reg <= hd_s1_reg;
    end
  end

  logic rd_act, wr_act, is_fifo, hi_half;
  logic [`SHP_CSR_IDX_W-1:0] csr_idx;
  assign rd_act  = !hb_s2_reg.cs_n && !hb_s2_reg.rd_n;
  assign wr_act  = !hb_s2_reg.cs_n && !hb_s2_reg.wr_n;
  // FIFO select overrides the upper address bits
  assign is_fifo = hb_s2_reg.fifo_sel ||
                   (hb_s2_reg.addr[`SHP_CSR_HI-1:`SHP_CSR_LO-1] == '0);
  assign hi_half = hb_s2_reg.addr[0];
  assign csr_idx = hb_s2_reg.addr[`SHP_CSR_HI-1:`SHP_CSR_LO-1];

  // CSRs and access state
  shp_state_t               st_reg, st_next;
  logic [`SHP_WORD_W-1:0]   cfg_reg, cfg_next;
  logic [`SHP_WORD_W-1:0]   irqcfg_reg, irqcfg_next;
  logic [`SHP_WORD_W-1:0]   rdat_reg, rdat_next;
  logic [`SHP_HDATA_W-1:0]  wlo_reg, wlo_next;
  logic [`SHP_HDATA_W-1:0]  hout_reg, hout_next;
  logic                     armed_reg, armed_next;
  logic                     tx_push;
  logic                     rx_pop;
  logic [`SHP_WORD_W-1:0]   tx_wdata;
  logic                     txf_ready;
  shp_word_t                rxf;
  logic [`SHP_WORD_W-1:0]   csr_rd, wword;

  assign wword = {hd_s2_reg, wlo_reg};

  always_comb begin
    unique case (csr_idx)
      `SHP_CSR_CFG:      csr_rd = cfg_reg;
      `SHP_CSR_IRQCFG:   csr_rd = irqcfg_reg;
      `SHP_CSR_STATUS:   csr_rd = {{(`SHP_WORD_W-7){1'b0}}, irq_src,
                                   rxf.valid, txf_ready, sleep};
      `SHP_CSR_BYTETEST: csr_rd = `SHP_BYTETEST_VAL;
      default:           csr_rd = '0;
    endcase
  end

  always_comb begin
    st_next     = st_reg;
    cfg_next    = cfg_reg;
    irqcfg_next = irqcfg_reg;
    rdat_next   = rdat_reg;
    wlo_next    = wlo_reg;
    hout_next   = hout_reg;
    armed_next  = armed_reg;
    tx_push     = 1'b0;
    rx_pop      = 1'b0;
    tx_wdata    = wword;
    unique case (st_reg)
      SHP_SLEEP: begin
        // Any qualified write wakes; the write itself is dropped
        if (wr_act) begin
          st_next    = SHP_WRITE;
          armed_next = 1'b0;
          cfg_next[`SHP_CFG_SLEEP] = 1'b0;
        end
      end
      SHP_IDLE: begin
        // Read wins when both strobes show up in one sample
        if (rd_act) begin
          st_next = SHP_READ;
          // Low half fetches the full word; high half reuses it
          if (!hi_half) begin
            if (is_fifo) begin
              rdat_next = rxf.data;
              rx_pop    = rxf.valid;
            end else begin
              rdat_next = swap32(csr_rd, cfg_reg[`SHP_CFG_BIGEND]);
            end
          end
          hout_next  = hi_half ? rdat_next[`SHP_WORD_W-1:`SHP_HDATA_W]
                               : rdat_next[`SHP_HDATA_W-1:0];
          armed_next = 1'b1;
        end else if (wr_act) begin
          st_next = SHP_WRITE;
          // A write before the first read leaves no trace at all
          if (armed_reg) begin
            // Low half is only latched; the high half commits the word
            if (!hi_half) begin
              wlo_next = hd_s2_reg;
            end else if (is_fifo) begin
              // Dropped when full; software polls STATUS before writing
              tx_push = 1'b1;
            end else begin
              tx_wdata = swap32(wword, cfg_reg[`SHP_CFG_BIGEND]);
              if (csr_idx == `SHP_CSR_CFG) begin
                cfg_next = tx_wdata;
              end
              if (csr_idx == `SHP_CSR_IRQCFG) begin
                irqcfg_next = tx_wdata;
              end
            end
          end
        end
      end
      SHP_READ: begin
        if (!rd_act) begin
          st_next = SHP_IDLE;
        end
      end
      SHP_WRITE: begin
        if (!wr_act) begin
          st_next = cfg_reg[`SHP_CFG_SLEEP] ? SHP_SLEEP : SHP_IDLE;
        end
      end
      default: st_next = SHP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg     <= SHP_IDLE;
      cfg_reg    <= '0;
      irqcfg_reg <= `SHP_IRQCFG_RST;
      rdat_reg   <= '0;
      wlo_reg    <= '0;
      hout_reg   <= '0;
      armed_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cfg_reg    <= cfg_next;
      irqcfg_reg <= irqcfg_next;
      rdat_reg   <= rdat_next;
      wlo_reg    <= wlo_next;
      hout_reg   <= hout_next;
      armed_reg  <= armed_next;
    end
  end

  assign sleep      = (st_reg == SHP_SLEEP);
  assign hdata_out  = hout_reg;
  // Raw pins gate the drive so the bus releases without sync delay
  assign hdata_oe_n = !(!hbus.cs_n && !hbus.rd_n);

  // Interrupt pin: level, polarity and buffer type from software
  logic irq_lvl_reg, irq_lvl_next;
  always_comb begin
    irq_lvl_next = irqcfg_reg[`SHP_IRQ_EN] &&
      |(irq_src & irqcfg_reg[`SHP_IRQ_SRC_HI:`SHP_IRQ_SRC_LO]);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_lvl_reg <= 1'b0;
    end else begin
      irq_lvl_reg <= irq_lvl_next;
    end
  end
  assign irq_out  = irq_lvl_reg ~^ irqcfg_reg[`SHP_IRQ_POL];
  // Open-drain only ever pulls the pin low; the pull-up makes the high
  assign irq_oe_n = irqcfg_reg[`SHP_IRQ_PUSHPULL] ? 1'b0
                    : irq_out;

  // Data FIFOs
  // TX takes the packed host word; RX fills straight from the MAC
  shp_fifo #(.WIDTH(`SHP_WORD_W), .DEPTH(DEPTH)) u_txf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (tx_push),
    .in_ready  (txf_ready),
    .in_data   (wword),
    .out_valid (tx_word.valid),
    .out_ready (tx_ready),
    .out_data  (tx_word.data)
  );
  shp_fifo #(.WIDTH(`SHP_WORD_W), .DEPTH(DEPTH)) u_rxf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (rx_word.valid),
    .in_ready  (rx_ready),
    .in_data   (rx_word.data),
    .out_valid (rxf.valid),
    .out_ready (rx_pop),
    .out_data  (rxf.data)
  );
endmodule
`default_nettype wire

// File: logic/shp_cfg.svh
/*
  Constants for the SRAM-like host port: address map, field positions,
  reset values, widths and the FIFO depth.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH
`define SHP_ADDR_W        7
`define SHP_HDATA_W       16
`define SHP_WORD_W        32
`define SHP_FIFO_DEPTH    8
`define SHP_CSR_COUNT     16
`define SHP_CSR_IDX_W     4
`define SHP_FIFO_ABIT     2
`define SHP_CSR_HI        7
`define SHP_CSR_LO        4
`define SHP_CSR_CFG       4'h1
`define SHP_CSR_IRQCFG    4'h2
`define SHP_CSR_STATUS    4'h3
`define SHP_CSR_BYTETEST  4'h4
`define SHP_BYTETEST_VAL  32'h87654321
`define SHP_CFG_BIGEND    0
`define SHP_IRQ_POL       0
`define SHP_IRQ_PUSHPULL  1
`define SHP_IRQ_EN        2
`define SHP_IRQ_SRC_LO    4
`define SHP_IRQ_SRC_HI    7
`define SHP_CFG_SLEEP     8
`define SHP_IRQCFG_RST    32'h00000000
`endif

// File: logic/shp_pkg.sv
/*
  Types for the SRAM-like host port.
  Assumes shp_cfg.svh is on the include path.
*/
`default_nettype none
`include "shp_cfg.svh"
package shp_pkg;
  typedef struct packed {
    logic                     cs_n;
    logic                     rd_n;
    logic                     wr_n;
    logic                     fifo_sel;
    logic [`SHP_ADDR_W-1:0]   addr;
  } shp_hbus_t;

  typedef struct packed {
    logic                     valid;
    logic [`SHP_WORD_W-1:0]   data;
  } shp_word_t;

  typedef enum logic [3:0] {
    SHP_IDLE  = 4'b0001,
    SHP_READ  = 4'b0010,
    SHP_WRITE = 4'b0100,
    SHP_SLEEP = 4'b1000
  } shp_state_t;
endpackage
`default_nettype wire

// File: logic/shp_fifo.sv
/*
  Holds no logic: the word FIFO module sits in shp_host_port.sv, so that
  one design file carries the whole port.
  Assumes nothing of its surroundings.
*/
`default_nettype none
`default_nettype wire

// File: testbench/shp_host_port_assertions.sv
/*
  Pin-level checker for the host port.
  Assumes it is bound into shp_host_port; strobes stay low four clocks.
*/
`default_nettype none
module shp_hp_chk #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // Host pins
  input wire shp_pkg::shp_hbus_t hbus,
  input wire logic [15:0]        hdata_out,
  input wire logic               hdata_oe_n,
  // MAC side and power
  input wire shp_pkg::shp_word_t tx_word,
  input wire logic               tx_ready,
  input wire logic               sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  import shp_pkg::*;
  logic rd_act;
  logic wr_act;
  assign rd_act = !hbus.cs_n && !hbus.rd_n;
  assign wr_act = !hbus.cs_n && !hbus.wr_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_OE_ONLY_READ: assert property (!hdata_oe_n |-> rd_act)
    else $error("data bus driven outside a read");
  AST_OE_ON_READ: assert property (rd_act |-> !hdata_oe_n)
    else $error("read without bus drive");
  AST_CS_GATES_OE: assert property (hbus.cs_n |-> hdata_oe_n)
    else $error("bus driven with chip select high");
  AST_CS_GATES_TX: assert property (hbus.cs_n [*6] |=> !$rose(tx_word.valid))
    else $error("transmit word without a selected write");
  AST_RD_DATA_HOLD: assert property ($changed(hdata_out) |-> rd_act || $past(rd_act))
    else $error("read data changed outside a read");
  AST_TX_HOLD: assert property (tx_word.valid && !tx_ready |=>
    tx_word.valid && $stable(tx_word.data))
    else $error("transmit word dropped while stalled");
  AST_WAKE: assert property ((sleep && wr_act) [*2] |-> ##[1:3] !sleep)
    else $error("host write did not wake the device");
  AST_NO_WAKE: assert property ((sleep && !wr_act) [*6] |=> sleep)
    else $error("left sleep without a host write");
  cover property ($rose(sleep));
  cover property (sleep ##1 !sleep);
  cover property (tx_word.valid && tx_ready);
  cover property (rd_act ##1 !hdata_oe_n);
endmodule
bind shp_host_port shp_hp_chk #(.DEPTH(DEPTH)) shp_hp_chk_i (
  .sys_clk(sys_clk), .rst(rst), .hbus(hbus), .hdata_out(hdata_out),
  .hdata_oe_n(hdata_oe_n), .tx_word(tx_word), .tx_ready(tx_ready),
  .sleep(sleep));
`default_nettype wire

// File: testbench/shp_mac_model.sv
/*
  MAC-side model: sinks transmit words, sources a counted receive stream.
  Assumes one clock shared with the port.
*/
`default_nettype none
module shp_mac_model (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Transmit words from the port
  input  wire shp_pkg::shp_word_t tx_word,
  output logic                    tx_ready,
  // Receive words into the port
  output shp_pkg::shp_word_t      rx_word,
  input  wire logic               rx_ready,
  // Test controls
  input  wire logic               stall,
  input  wire logic [7:0]         rx_lim
);
  timeunit 1ns;
  timeprecision 1ps;
  import shp_pkg::*;
  logic [31:0] tx_q [$];
  logic [7:0]  rx_n;
  assign tx_ready = !stall;
  // Idle data is scrambled so a stale read cannot pass by luck
  assign rx_word.valid = rx_n < rx_lim;
  assign rx_word.data = rx_word.valid ? {24'hc0de00, rx_n} : {24'h3f21a5, ~rx_n};
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_n <= 8'h00;
    end else if (rx_word.valid && rx_ready) begin
      rx_n <= rx_n + 8'h01;
    end
    if (!rst && tx_word.valid && tx_ready) begin
      tx_q.push_back(tx_word.data);
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the SRAM-like host port.
  Assumes shp_mac_model on the MAC side; host strobes last five clocks.
*/
`default_nettype none
`include "shp_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import shp_pkg::*;
  typedef struct packed {
    logic [31:0] cfg;
    logic [3:0]  src;
    logic [1:0]  pin;
  } shp_row_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        stall = 1'b0;
  logic [7:0]  rx_lim = 8'h00;
  logic [3:0]  irq_src = 4'h0;
  logic [15:0] hdata_in = 16'h0000;
  logic [15:0] hdata_out;
  logic [15:0] rdat;
  logic [31:0] r32;
  logic        hdata_oe_n, irq_out, irq_oe_n, tx_ready, rx_ready, sleep;
  shp_hbus_t   hbus = '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00};
  shp_word_t   tx_word, rx_word;
  int          err_count = 0;
  int          n_compared = 0;
  shp_row_t    rows [6] = '{'{32'h06, 4'h0, 2'h2}, '{32'h17, 4'h0, 2'h0},
                            '{32'h17, 4'h1, 2'h2}, '{32'h14, 4'h1, 2'h0},
                            '{32'h15, 4'h0, 2'h0}, '{32'h15, 4'h1, 2'h3}};
  localparam logic [6:0] BT = {`SHP_CSR_BYTETEST, 3'h0};
  always #10 sys_clk = ~sys_clk;
  shp_host_port #(.DEPTH(8)) shp_host_port_i (.sys_clk(sys_clk), .rst(rst),
    .hbus(hbus), .hdata_in(hdata_in), .hdata_out(hdata_out),
    .hdata_oe_n(hdata_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .irq_src(irq_src), .tx_word(tx_word), .tx_ready(tx_ready),
    .rx_word(rx_word), .rx_ready(rx_ready), .sleep(sleep));
  shp_mac_model shp_mac_model_i (.sys_clk(sys_clk), .rst(rst),
    .tx_word(tx_word), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_ready(rx_ready), .stall(stall), .rx_lim(rx_lim));
  task automatic acc(input logic w, fs, cs, input logic [6:0] a,
                     input logic [15:0] d);
    @(negedge sys_clk);
    hbus = '{!cs, w, !w, fs, a};
    hdata_in = d;
    repeat (5) @(negedge sys_clk);
    rdat = hdata_out;
    hbus = '{1'b1, 1'b1, 1'b1, fs, a};
    hdata_in = ~d;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic wr32(input logic fs, cs, input logic [6:0] a,
                      input logic [31:0] d);
    acc(1'b1, fs, cs, {a[6:1], 1'b0}, d[15:0]);
    acc(1'b1, fs, cs, {a[6:1], 1'b1}, d[31:16]);
  endtask
  task automatic rd32(input logic fs, input logic [6:0] a);
    acc(1'b0, fs, 1'b1, {a[6:1], 1'b0}, 16'h0000);
    r32[15:0] = rdat;
    acc(1'b0, fs, 1'b1, {a[6:1], 1'b1}, 16'h0000);
    r32[31:16] = rdat;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    wr32(1'b1, 1'b1, 7'h78, 32'h1111_2222);
    chk(shp_mac_model_i.tx_q.size(), 0);
    rd32(1'b0, BT);
    chk(r32, `SHP_BYTETEST_VAL);
    $display("test reset_order done");
    foreach (rows[i]) begin
      wr32(1'b0, 1'b1, {`SHP_CSR_IRQCFG, 3'h0}, rows[i].cfg);
      irq_src = rows[i].src;
      repeat (4) @(negedge sys_clk);
      chk({irq_out, irq_oe_n}, rows[i].pin);
    end
    $display("test irq_rows done");
    wr32(1'b0, 1'b1, {`SHP_CSR_CFG, 3'h0}, 32'h0000_0001);
    rd32(1'b0, BT);
    chk(r32, 32'h2143_6587);
    wr32(1'b0, 1'b1, {`SHP_CSR_CFG, 3'h0}, 32'h0000_0000);
    rd32(1'b0, BT);
    chk(r32, `SHP_BYTETEST_VAL);
    $display("test big_endian done");
    wr32(1'b1, 1'b1, 7'h7c, 32'ha5a5_0001);
    wr32(1'b0, 1'b1, 7'h02, 32'h5a5a_0002);
    wr32(1'b1, 1'b0, 7'h00, 32'hdead_0003);
    chk(shp_mac_model_i.tx_q.size(), 2);
    chk(shp_mac_model_i.tx_q[0], 32'ha5a5_0001);
    chk(shp_mac_model_i.tx_q[1], 32'h5a5a_0002);
    shp_mac_model_i.tx_q.delete();
    $display("test routing done");
    stall = 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr32(1'b1, 1'b1, 7'h00, 32'h7700_0000 + i);
    end
    stall = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk(shp_mac_model_i.tx_q.size(), 8);
    chk(shp_mac_model_i.tx_q[7], 32'h7700_0007);
    $display("test tx_full done");
    rx_lim = 8'h08;
    for (int k = 0; k < 40 && rx_ready; k++) @(negedge sys_clk);
    chk(rx_ready, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd32(1'b1, 7'h50);
      chk(r32, 32'hc0de_0000 + i);
    end
    chk(rx_ready, 1'b1);
    $display("test rx_drain done");
    wr32(1'b0, 1'b1, {`SHP_CSR_CFG, 3'h0}, 32'h1 << `SHP_CFG_SLEEP);
    rd32(1'b1, 7'h50);
    repeat (8) @(negedge sys_clk);
    chk(sleep, 1'b1);
    wr32(1'b0, 1'b1, BT, 32'h0000_0000);
    chk(sleep, 1'b0);
    wr32(1'b1, 1'b1, 7'h00, 32'hbad0_0005);
    chk(shp_mac_model_i.tx_q.size(), 8);
    $display("test wake done");
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({hdata_out, irq_oe_n, sleep, tx_word.valid, rx_ready}, 20'h00009);
    rst = 1'b0;
    $display("test mid_reset done");
    finish_test();
  end
endmodule
`default_nettype wire
